// [pmps_pkg.sv]
package pmps_pkg;
	// ----------------------------------------
	// register map (byte addresses)
	// ----------------------------------------
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_STATUS = 4'h4;
	localparam logic [3:0] ADDR_WDLIMIT = 4'h8;
	localparam logic [3:0] ADDR_ERRINJ = 4'hc;
	// ctrl fields
	localparam int CTRL_SLEEPINV = 0;
	localparam int CTRL_QPUSEL = 1;
	localparam int CTRL_EDGEMODE = 2;
	localparam int CTRL_OVLODIS = 3;
	localparam int CTRL_CNTCLR = 4;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [3:0] WDLIMIT_RESET = 4'h4;
	localparam logic [31:0] UNMAPPED_DATA = 32'hdead_0000;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_MHZ = 250;
	localparam int WD_DELAY_US = 30;
	localparam int WD_DELAY_CYC = WD_DELAY_US * CLK_MHZ;
	localparam int WDCNT_W = 4;
	// ----------------------------------------
	// states, one-hot
	// ----------------------------------------
	typedef enum logic [5:0] {
		ST_LPOFF = 6'h01,
		ST_QPUOFF = 6'h02,
		ST_RUN = 6'h04,
		ST_SLEEP = 6'h08,
		ST_WDRST = 6'h10,
		ST_FAULTPD = 6'h20
	} pmps_state_e;
	// monitor inputs bundled
	typedef struct packed {
		logic vinOk;
		logic vinOvlo;
		logic thermalShutdown;
		logic trimCrcBad;
		logic fuseCrcBad;
	} pmps_mon_s;
endpackage

// [pmps_sync.sv]
`timescale 1ns/100ps
module pmps_sync #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// data
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	logic [W-1:0] meta_ff;
	logic [W-1:0] sync_ff;
	always_ff @(posedge core_clk) begin
		if (rst) begin
			meta_ff <= '0;
			sync_ff <= '0;
		end else begin
			meta_ff <= din;
			sync_ff <= meta_ff;
		end
	end
	assign dout = sync_ff;
endmodule // pmps_sync

// [pmps_power_state.sv]
// Added by the designer: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/100ps
module pmps_power_state
	import pmps_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// avalon-mm slave
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// pins from host and monitors
	input wire logic standbyPin,
	input wire logic powerOnRequest,
	input wire logic testBypassEnable,
	input wire logic hardWdEvent,
	input wire pmps_mon_s monitors,
	// fuse load check results, same clock
	input wire logic loadDone,
	input wire logic trimCrcFail,
	input wire logic fuseCrcFail,
	// state outputs
	output pmps_state_e powerState,
	output logic systemOn
);
	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	logic [8:0] pinRaw;
	logic [8:0] pinSync;
	assign pinRaw = {standbyPin, powerOnRequest, testBypassEnable, hardWdEvent, monitors};
	pmps_sync #(.W(9)) u_sync (
		.core_clk(core_clk),
		.rst(rst),
		.din(pinRaw),
		.dout(pinSync)
	);
	wire standbyS = pinSync[8];
	wire pwrOnS = pinSync[7];
	wire bypassS = pinSync[6];
	wire wdEventS = pinSync[5];
	wire vinOkS = pinSync[4];
	wire ovloS = pinSync[3];
	wire tsdS = pinSync[2];
	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic [31:0] ctrl_ff;
	logic [WDCNT_W-1:0] wdLimit_ff;
	logic [WDCNT_W-1:0] wdCount_ff;
	logic trimErr_ff;
	logic fuseErr_ff;
	logic vinQual_ff;
	logic pwrOnPrev_ff;
	logic [15:0] wdTimer_ff;
	logic rdPend_ff;
	logic [31:0] rdData_ff;
	pmps_state_e state_ff;
	pmps_state_e nxt_state;
	wire sleepInv = ctrl_ff[CTRL_SLEEPINV];
	wire qpuSel = ctrl_ff[CTRL_QPUSEL];
	wire edgeMode = ctrl_ff[CTRL_EDGEMODE];
	wire ovloDis = ctrl_ff[CTRL_OVLODIS];
	// ----------------------------------------
	// bus decode
	// ----------------------------------------
	wire wrCtrl = avs_write && avs_address == ADDR_CTRL;
	wire wrLimit = avs_write && avs_address == ADDR_WDLIMIT;
	wire [31:0] statusWord = {16'h0000, 2'b00, state_ff, trimErr_ff, fuseErr_ff, vinQual_ff,
		bypassS, wdCount_ff};
	wire [31:0] rdMux = (avs_address == ADDR_CTRL) ? ctrl_ff :
		(avs_address == ADDR_STATUS) ? statusWord :
		(avs_address == ADDR_WDLIMIT) ? {28'h0000000, wdLimit_ff} :
		(avs_address == ADDR_ERRINJ) ? 32'h0000_0000 : UNMAPPED_DATA;
	assign avs_waitrequest = avs_read && !rdPend_ff;
	assign avs_readdata = rdData_ff;
	always_ff @(posedge core_clk) begin
		if (rst) begin
			rdPend_ff <= 1'b0;
			rdData_ff <= 32'h0000_0000;
		end else begin
			rdPend_ff <= avs_read && !rdPend_ff;
			rdData_ff <= rdMux;
		end
	end
	// ----------------------------------------
	// control and flags
	// ----------------------------------------
	wire vinFirstQual = vinOkS && !vinQual_ff;
	always_ff @(posedge core_clk) begin
		if (rst) begin
			ctrl_ff <= CTRL_RESET;
			wdLimit_ff <= WDLIMIT_RESET;
			vinQual_ff <= 1'b0;
		end else begin
			vinQual_ff <= vinQual_ff | vinOkS;
			if (wrCtrl)
				ctrl_ff <= {27'h0000000, 1'b0, avs_writedata[3:0]};
			if (wrLimit)
				wdLimit_ff <= avs_writedata[WDCNT_W-1:0];
			if (vinFirstQual)
				ctrl_ff[CTRL_QPUSEL] <= 1'b0;
		end
	end
	always_ff @(posedge core_clk) begin
		if (rst) begin
			trimErr_ff <= 1'b0;
			fuseErr_ff <= 1'b0;
		end else if (loadDone) begin
			trimErr_ff <= trimCrcFail;
			fuseErr_ff <= fuseCrcFail;
		end
	end
	// ----------------------------------------
	// transition conditions
	// ----------------------------------------
	wire sleepReq = standbyS ^ sleepInv;
	wire supplyOk = vinOkS && (ovloDis || !ovloS) && !tsdS && !trimErr_ff && !fuseErr_ff;
	wire pwrFall = pwrOnPrev_ff && !pwrOnS;
	wire levelEvt = !edgeMode && pwrOnS;
	wire edgeEvt = edgeMode && pwrFall;
	wire powerUpEvt = supplyOk && (levelEvt || edgeEvt);
	wire lpToQpu = bypassS || qpuSel || powerUpEvt;
	wire wdDone = wdTimer_ff == 16'(WD_DELAY_CYC - 1);
	wire isOn = state_ff == ST_RUN || state_ff == ST_SLEEP;
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_LPOFF: begin
				if (lpToQpu)
					nxt_state = ST_QPUOFF;
			end
			ST_RUN: begin
				if (wdEventS)
					nxt_state = ST_WDRST;
				else if (sleepReq)
					nxt_state = ST_SLEEP;
			end
			ST_SLEEP: begin
				if (wdEventS)
					nxt_state = ST_WDRST;
				else if (!sleepReq)
					nxt_state = ST_RUN;
			end
			ST_WDRST: begin
				if (wdCount_ff >= wdLimit_ff)
					nxt_state = ST_FAULTPD;
				else if (wdDone)
					nxt_state = ST_RUN;
			end
			ST_QPUOFF: begin
				// power-up sequence lives elsewhere; direct hop to run stands in for it
				if (powerUpEvt)
					nxt_state = ST_RUN;
			end
			ST_FAULTPD: nxt_state = ST_FAULTPD;
			default: nxt_state = ST_LPOFF;
		endcase
	end
	// ----------------------------------------
	// state, counter, timer
	// ----------------------------------------
	wire wdEntry = nxt_state == ST_WDRST && state_ff != ST_WDRST;
	always_ff @(posedge core_clk) begin
		if (rst) begin
			state_ff <= ST_LPOFF;
			pwrOnPrev_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			pwrOnPrev_ff <= pwrOnS;
		end
	end
	always_ff @(posedge core_clk) begin
		if (rst)
			wdCount_ff <= '0;
		else if (wdEntry)
			wdCount_ff <= wdCount_ff + 1'b1;
		else if (wrCtrl && avs_writedata[CTRL_CNTCLR])
			wdCount_ff <= '0;
	end
	always_ff @(posedge core_clk) begin
		if (rst || state_ff != ST_WDRST)
			wdTimer_ff <= '0;
		else if (!wdDone)
			wdTimer_ff <= wdTimer_ff + 1'b1;
	end
	assign powerState = state_ff;
	assign systemOn = isOn;
	// ----------------------------------------
	// assertions
	// ----------------------------------------
	property p_wake;
		@(posedge core_clk) disable iff (rst) state_ff == ST_SLEEP && !wdEventS && !sleepReq |=> state_ff == ST_RUN;
	endproperty
	a_wake: assert property (p_wake) else $error("sleep did not wake");
	property p_sleep;
		@(posedge core_clk) disable iff (rst) state_ff == ST_RUN && !wdEventS && sleepReq |=> state_ff == ST_SLEEP;
	endproperty
	a_sleep: assert property (p_sleep) else $error("run did not sleep");
	property p_wdEnter;
		@(posedge core_clk) disable iff (rst) isOn && wdEventS |=> state_ff == ST_WDRST;
	endproperty
	a_wdEnter: assert property (p_wdEnter) else $error("watchdog entry missed");
	// dwell counter, independent of the exit timer
	logic [15:0] wdDwell_ff;
	always_ff @(posedge core_clk) begin
		if (rst || state_ff != ST_WDRST)
			wdDwell_ff <= '0;
		else
			wdDwell_ff <= wdDwell_ff + 16'h0001;
	end
	property p_wdExit;
		@(posedge core_clk) disable iff (rst) state_ff == ST_WDRST && wdCount_ff < wdLimit_ff
			|=> state_ff == (($past(wdDwell_ff) == 16'(WD_DELAY_CYC - 1)) ? ST_RUN : ST_WDRST);
	endproperty
	a_wdExit: assert property (p_wdExit) else $error("watchdog exit timing wrong");
	property p_fault;
		@(posedge core_clk) disable iff (rst) state_ff == ST_WDRST && wdCount_ff == wdLimit_ff |=> state_ff == ST_FAULTPD;
	endproperty
	a_fault: assert property (p_fault) else $error("fault escalation missed");
	property p_bypass;
		@(posedge core_clk) disable iff (rst) state_ff == ST_LPOFF && (bypassS || qpuSel) |=> state_ff == ST_QPUOFF;
	endproperty
	a_bypass: assert property (p_bypass) else $error("quick off not entered");
	property p_lpHold;
		@(posedge core_clk) disable iff (rst) state_ff == ST_LPOFF && !bypassS && !qpuSel && !supplyOk
			|=> state_ff == ST_LPOFF;
	endproperty
	a_lpHold: assert property (p_lpHold) else $error("left low-power off unqualified");
	property p_count;
		@(posedge core_clk) disable iff (rst) wdEntry |=> wdCount_ff == $past(wdCount_ff) + 1'b1;
	endproperty
	a_count: assert property (p_count) else $error("event count not incremented");
	property p_qpuClr;
		@(posedge core_clk) disable iff (rst) vinFirstQual |=> !qpuSel;
	endproperty
	a_qpuClr: assert property (p_qpuClr) else $error("quick select not cleared");
	c_wd: cover property (@(posedge core_clk) disable iff (rst) state_ff == ST_WDRST ##1 state_ff == ST_RUN);
	c_fault: cover property (@(posedge core_clk) disable iff (rst) state_ff == ST_FAULTPD);
	c_sleep: cover property (@(posedge core_clk) disable iff (rst) state_ff == ST_SLEEP ##1 state_ff == ST_RUN);
	c_qpu: cover property (@(posedge core_clk) disable iff (rst) state_ff == ST_LPOFF ##1 state_ff == ST_QPUOFF);
endmodule // pmps_power_state

// [pmps_host_model.sv]
`timescale 1ns/100ps
module pmps_host_model (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// control from bench
	input wire logic edgeMode,
	input wire logic go,
	input wire logic sleepLevel,
	// pins to device
	output logic powerOnRequest,
	output logic standbyPin
);
	logic [3:0] holdCnt_ff;
	assign standbyPin = sleepLevel;
	// level held high, or high then falling edge
	always_ff @(posedge core_clk) begin
		if (rst) begin
			powerOnRequest <= 1'b0;
			holdCnt_ff <= 4'h0;
		end else if (go) begin
			powerOnRequest <= 1'b1;
			holdCnt_ff <= edgeMode ? 4'h8 : 4'h0;
		end else if (holdCnt_ff != 4'h0) begin
			holdCnt_ff <= holdCnt_ff - 4'h1;
			if (holdCnt_ff == 4'h1) begin
				powerOnRequest <= 1'b0;
			end
		end
	end
endmodule // pmps_host_model

// [tb.sv]
`timescale 1ns/100ps
module tb
	import pmps_pkg::*;
;
	logic core_clk = 0, rst = 1, avs_read = 0, avs_write = 0, testBypassEnable = 0, hardWdEvent = 0;
	logic loadDone = 0, trimCrcFail = 0, fuseCrcFail = 0, edgeMode = 0, go = 0, sleepLevel = 0;
	logic [3:0] avs_address = 4'h0;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, rd, lim;
	logic avs_waitrequest, standbyPin, powerOnRequest, systemOn;
	pmps_mon_s monitors = '0;
	pmps_state_e powerState;
	int failures = 0, num_checks = 0, cyc = 0, n = 0;
	logic inv = 0;
	// [9]edge [8]ovlo off [7]sel [6]bypass [5]vin [4]ovlo [3]hot [2]trim [1]fuse [0]request
	logic [9:0] cases [13] = '{10'h020, 10'h0a0, 10'h040, 10'h0c0, 10'h021, 10'h001, 10'h031,
		10'h131, 10'h029, 10'h025, 10'h023, 10'h221, 10'h229};
	always #2 core_clk = ~core_clk;
	pmps_power_state DUT (.core_clk(core_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .standbyPin(standbyPin), .powerOnRequest(powerOnRequest),
		.testBypassEnable(testBypassEnable), .hardWdEvent(hardWdEvent), .monitors(monitors),
		.loadDone(loadDone), .trimCrcFail(trimCrcFail), .fuseCrcFail(fuseCrcFail),
		.powerState(powerState), .systemOn(systemOn));
	pmps_host_model host (.core_clk(core_clk), .rst(rst), .edgeMode(edgeMode), .go(go),
		.sleepLevel(sleepLevel), .powerOnRequest(powerOnRequest), .standbyPin(standbyPin));
	// ----------------------------------------
	// checking and closing
	// ----------------------------------------
	task automatic tally_and_finish;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("BAD %0t register got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chk_state(input logic [5:0] exp);
		num_checks++;
		if (powerState !== exp || systemOn !== (exp == 6'h04 || exp == 6'h08)) begin
			failures++;
			$display("BAD %0t state got %h exp %h", $time, powerState, exp);
		end
	endtask
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 20000) begin
			failures++;
			$display("BAD %0t timeout", $time);
			tally_and_finish;
		end
	end
	// ----------------------------------------
	// bus and reset
	// ----------------------------------------
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic do_reset;
		rst <= 1'b1;
		repeat (8) @(posedge core_clk);
		rst <= 1'b0;
		repeat (6) @(posedge core_clk);
	endtask
	// ----------------------------------------
	// reference model and cases
	// ----------------------------------------
	function automatic logic [5:0] model_state(logic [9:0] c, logic slp, logic wd);
		logic ok;
		ok = c[0] && c[5] && (!c[4] || c[8]) && !c[3] && !c[2] && !c[1];
		if (ok && !c[9]) return wd ? 6'h10 : (slp ? 6'h08 : 6'h04);
		return (c[6] || c[7] || ok) ? 6'h02 : 6'h01;
	endfunction
	task automatic run_case(input logic [9:0] c);
		logic [31:0] q;
		logic slp, wd;
		logic [5:0] e;
		slp = 1'($urandom);
		wd = 1'($urandom);
		e = model_state(c, slp, wd);
		monitors <= '{vinOk: c[5], vinOvlo: c[4], thermalShutdown: c[3], trimCrcBad: 1'b0, fuseCrcBad: 1'b0};
		testBypassEnable <= c[6];
		edgeMode <= c[9];
		sleepLevel <= slp;
		do_reset;
		trimCrcFail <= c[2];
		fuseCrcFail <= c[1];
		loadDone <= 1'b1;
		@(posedge core_clk);
		loadDone <= 1'b0;
		bus(1'b1, ADDR_CTRL, {28'h0, c[8], c[9], c[7], 1'b0}, q);
		hardWdEvent <= wd;
		go <= c[0];
		@(posedge core_clk);
		go <= 1'b0;
		if (c[9] && c[0]) begin
			repeat (4) @(posedge core_clk);
			chk_state(6'h01);
		end
		repeat (24) @(posedge core_clk);
		chk_state(e);
		bus(1'b0, ADDR_STATUS, 32'h0, q);
		chk_reg(32'(q[13:6]), 32'({e, c[2], c[1]}));
		hardWdEvent <= 1'b0;
	endtask
	initial begin
		void'($urandom(32'hf177fa38));
		do_reset;
		bus(1'b0, ADDR_CTRL, 32'h0, rd);
		chk_reg(rd, CTRL_RESET);
		bus(1'b0, ADDR_WDLIMIT, 32'h0, rd);
		chk_reg(rd, {28'h0, WDLIMIT_RESET});
		bus(1'b0, ADDR_ERRINJ, 32'h0, rd);
		chk_reg(rd, 32'h0);
		bus(1'b1, 4'h2, 32'hffff_ffff, rd);
		bus(1'b0, 4'h2, 32'h0, rd);
		chk_reg(rd, UNMAPPED_DATA);
		bus(1'b0, ADDR_CTRL, 32'h0, rd);
		chk_reg(rd, CTRL_RESET);
		lim = 32'($urandom_range(15, 1));
		bus(1'b1, ADDR_WDLIMIT, lim, rd);
		bus(1'b0, ADDR_WDLIMIT, 32'h0, rd);
		chk_reg(rd, lim);
		foreach (cases[i]) run_case(cases[i]);
		// ----------------------------------------
		// system on, sleep, watchdog
		// ----------------------------------------
		monitors <= '{vinOk: 1'b1, vinOvlo: 1'b0, thermalShutdown: 1'b0, trimCrcBad: 1'b0, fuseCrcBad: 1'b0};
		testBypassEnable <= 1'b0;
		edgeMode <= 1'b0;
		trimCrcFail <= 1'b0;
		fuseCrcFail <= 1'b0;
		inv = 1'($urandom);
		sleepLevel <= inv;
		do_reset;
		bus(1'b1, ADDR_WDLIMIT, 32'h2, rd);
		bus(1'b1, ADDR_CTRL, {31'h0, inv}, rd);
		go <= 1'b1;
		@(posedge core_clk);
		go <= 1'b0;
		repeat (10) @(posedge core_clk);
		chk_state(6'h04);
		sleepLevel <= !inv;
		repeat (6) @(posedge core_clk);
		chk_state(6'h08);
		sleepLevel <= inv;
		repeat (6) @(posedge core_clk);
		chk_state(6'h04);
		hardWdEvent <= 1'b1;
		@(posedge core_clk);
		hardWdEvent <= 1'b0;
		n = 0;
		while (powerState !== ST_WDRST) @(posedge core_clk);
		while (powerState === ST_WDRST) begin
			@(posedge core_clk);
			n++;
		end
		chk_reg(32'(n), 32'(WD_DELAY_CYC));
		chk_state(6'h04);
		bus(1'b0, ADDR_STATUS, 32'h0, rd);
		chk_reg(32'(rd[3:0]), 32'h1);
		hardWdEvent <= 1'b1;
		@(posedge core_clk);
		hardWdEvent <= 1'b0;
		repeat (6) @(posedge core_clk);
		chk_state(6'h20);
		bus(1'b0, ADDR_STATUS, 32'h0, rd);
		chk_reg(32'(rd[3:0]), 32'h2);
		bus(1'b1, ADDR_CTRL, 32'h10, rd);
		bus(1'b0, ADDR_STATUS, 32'h0, rd);
		chk_reg(32'(rd[3:0]), 32'h0);
		tally_and_finish;
	end
endmodule // tb
